// *** core/pin_sync.sv ***
// pad model with weak pull-up followed by a two-stage synchroniser
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // pad side
  input wire logic [WIDTH-1:0] level_in,
  input wire logic [WIDTH-1:0] driven_in,
  // core side
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] pad_level;
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // an undriven pad floats high; an external driver wins
  assign pad_level = (driven_in & level_in) | ~driven_in;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= pad_level;
      sync_q <= meta_q;
    end
  end

  assign level_out = sync_q;

endmodule : pin_sync

// *** core/pld_cfg_pkg.sv ***
// constants, field layouts and mode encodings of the configurable logic block
package pld_cfg_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CELLS = 8;
  localparam int ARRAY_IN = 2 * CELLS;
  localparam int PAT_WORDS = 2 * CELLS;
  localparam int SIG_BITS = 64;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CELLCFG_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SECURE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] PRELOAD_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] SIG_LO_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] SIG_HI_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] PAT_BASE_OFS = 8'h40;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SECURE_BIT = 0;
  localparam int PRELOAD_MASK_LSB = 0;
  localparam int PRELOAD_VAL_LSB = 8;
  localparam int STATUS_SECURE_BIT = 0;
  localparam int STATUS_READY_BIT = 1;
  localparam int STATUS_REGS_LSB = 8;
  localparam int STATUS_MODE_LSB = 16;
  localparam int TERM_TRUE_LSB = 0;
  localparam int TERM_COMP_LSB = 16;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SIMPLE = 2'h0,
    MODE_COMPLEX = 2'h1,
    MODE_REGISTERED = 2'h2
  } arch_mode_e;

  typedef enum logic [1:0] {
    CELL_REG_OUT = 2'h0,
    CELL_COMB_IO = 2'h1,
    CELL_COMB_OUT = 2'h2,
    CELL_INPUT = 2'h3
  } cell_cfg_e;

  localparam logic [1:0] MODE_RESERVED = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] CELLCFG_RST = 16'hffff;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;
  localparam logic [31:0] SIG_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int POR_TYP_NS = 600;
  localparam int POR_MAX_NS = 1000;
  localparam int POR_CYCLES = (POR_MAX_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_CNT_W = $clog2(POR_CYCLES + 1);

endpackage : pld_cfg_pkg

// *** core/pld_core.sv ***
// configurable eight-macrocell logic block with power-up reset, preload and security
//
// Notes on behaviour
// - after the power-up reset every macrocell register is forced low, no reset pin involved.
// - registered outputs are the inverted register, so they show high right after power-up reset.
// - each macrocell register can be preloaded individually to high or low.
// - once the security fuse is set, pattern readback and preload are refused.
// - a 64-bit user signature stays readable and writable whether or not the fuse is set.
// - each macrocell is a registered output, combinatorial I/O, combinatorial output or dedicated input.
// - the block runs in exactly one of three global modes: registered, complex or simple.
// - in registered mode registered outputs use the output-enable pin and clock pin; comb outputs a term.
module pld_core
  import pld_cfg_pkg::*;
#(
  parameter int NUM_CELLS = pld_cfg_pkg::CELLS
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // axi4-lite write address
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [pld_cfg_pkg::ADDR_W-1:0] awaddr_in,
  // axi4-lite write data
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // axi4-lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // axi4-lite read address
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [pld_cfg_pkg::ADDR_W-1:0] araddr_in,
  // axi4-lite read data
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // dedicated input pins
  input wire logic [pld_cfg_pkg::CELLS-1:0] ded_pin_in,
  input wire logic [pld_cfg_pkg::CELLS-1:0] ded_pin_driven_in,
  // common clock and output-enable pins
  input wire logic pld_clk_pin_in,
  input wire logic pld_clk_driven_in,
  input wire logic oe_b_pin_in,
  input wire logic oe_b_driven_in,
  // macrocell i/o pins
  input wire logic [pld_cfg_pkg::CELLS-1:0] io_pin_in,
  input wire logic [pld_cfg_pkg::CELLS-1:0] io_pin_driven_in,
  output logic [pld_cfg_pkg::CELLS-1:0] io_pin_out,
  output logic [pld_cfg_pkg::CELLS-1:0] io_pin_oe_out,
  // status
  output logic powerup_done_out
);
  import pld_cfg_pkg::*;

  if (NUM_CELLS != CELLS) begin : g_cells_check
    $error("pld_core supports exactly eight macrocells");
  end

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // product term: every selected true input high and every selected complement input low
  function automatic logic term_eval(input logic [31:0] word, input logic [ARRAY_IN-1:0] arr);
    logic t;
    logic c;
    t = &(~word[TERM_TRUE_LSB +: ARRAY_IN] | arr);
    c = &(~word[TERM_COMP_LSB +: ARRAY_IN] | ~arr);
    return t & c;
  endfunction : term_eval

  function automatic logic pat_addr(input logic [ADDR_W-1:0] a);
    return (a >= PAT_BASE_OFS) && (a < PAT_BASE_OFS + 8'(4 * PAT_WORDS)) && (a[1:0] == 2'h0);
  endfunction : pat_addr

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  logic [CELLS-1:0] ded_sync;
  logic [CELLS-1:0] io_sync;
  logic clk_pin_sync;
  logic oe_b_sync;
  logic clk_pin_prev_q;
  logic clk_rise;

  pin_sync #(.WIDTH(CELLS)) u_ded_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .level_in(ded_pin_in),
    .driven_in(ded_pin_driven_in),
    .level_out(ded_sync)
  );

  pin_sync #(.WIDTH(CELLS)) u_io_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .level_in(io_pin_in),
    .driven_in(io_pin_driven_in),
    .level_out(io_sync)
  );

  pin_sync #(.WIDTH(2)) u_ctl_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .level_in({pld_clk_pin_in, oe_b_pin_in}),
    .driven_in({pld_clk_driven_in, oe_b_driven_in}),
    .level_out({clk_pin_sync, oe_b_sync})
  );

  assign clk_rise = clk_pin_sync & ~clk_pin_prev_q;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic [15:0] cellcfg_q;
  logic secure_q;
  logic [31:0] sig_q [2];
  logic [31:0] pat_q [PAT_WORDS];
  logic [CELLS-1:0] cell_q;
  logic [CELLS-1:0] cell_d;
  logic [POR_CNT_W-1:0] por_cnt_q;
  logic por_done;
  logic [CELLS-1:0] io_out_q;
  logic [CELLS-1:0] io_out_d;
  logic [CELLS-1:0] io_oe_q;
  logic [CELLS-1:0] io_oe_d;

  // the power-up reset interval runs after release; clock pin edges are ignored meanwhile
  assign por_done = (por_cnt_q == POR_CNT_W'(POR_CYCLES));

  // ----------------------------------------------------------------
  // logic array and macrocells
  // ----------------------------------------------------------------
  logic [CELLS-1:0] is_reg;
  logic [CELLS-1:0] is_input;
  logic [CELLS-1:0] feedback;
  logic [ARRAY_IN-1:0] array_in;
  logic [CELLS-1:0] sum_term;
  logic [CELLS-1:0] oe_term;

  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    wire [1:0] cfg = cellcfg_q[2*i +: 2];
    // a registered cell only exists in registered mode; elsewhere it acts as comb i/o
    assign is_reg[i] = (mode_q == MODE_REGISTERED) && (cfg == CELL_REG_OUT);
    assign is_input[i] = (cfg == CELL_INPUT);
    assign feedback[i] = is_reg[i] ? cell_q[i] : io_sync[i];
    assign sum_term[i] = term_eval(pat_q[i], array_in);
    assign oe_term[i] = term_eval(pat_q[CELLS + i], array_in);
    assign io_out_d[i] = is_reg[i] ? ~cell_q[i] : sum_term[i];
    assign io_oe_d[i] = is_input[i] ? 1'b0 :
                        is_reg[i] ? ~oe_b_sync :
                        (mode_q == MODE_SIMPLE) ? 1'b1 : oe_term[i];
  end

  assign array_in = {feedback, ded_sync};

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic wr_mode;
  logic wr_cellcfg;
  logic wr_secure;
  logic wr_preload;
  logic wr_sig_lo;
  logic wr_sig_hi;
  logic wr_pat;
  logic wr_mapped;
  logic wr_err;
  logic preload_go;
  logic [3:0] wr_pat_idx;
  logic [CELLS-1:0] pl_mask;
  logic [CELLS-1:0] pl_val;

  assign awready_out = ~aw_have_q;
  assign wready_out = ~w_have_q;
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_pat_idx = 4'((aw_addr_q - PAT_BASE_OFS) >> 2);
  assign wr_mode = do_write && (aw_addr_q == MODE_OFS);
  assign wr_cellcfg = do_write && (aw_addr_q == CELLCFG_OFS);
  assign wr_secure = do_write && (aw_addr_q == SECURE_OFS);
  assign wr_preload = do_write && (aw_addr_q == PRELOAD_OFS);
  assign wr_sig_lo = do_write && (aw_addr_q == SIG_LO_OFS);
  assign wr_sig_hi = do_write && (aw_addr_q == SIG_HI_OFS);
  assign wr_pat = do_write && pat_addr(aw_addr_q);
  assign wr_mapped = wr_mode | wr_cellcfg | wr_secure | wr_preload | wr_sig_lo | wr_sig_hi | wr_pat |
                     (aw_addr_q == STATUS_OFS);
  assign wr_err = ~wr_mapped | (wr_preload & secure_q);
  assign preload_go = wr_preload & ~secure_q;
  assign wr_old = wr_mode ? {30'h0, mode_q} :
                  wr_cellcfg ? {16'h0, cellcfg_q} :
                  wr_sig_lo ? sig_q[0] :
                  wr_sig_hi ? sig_q[1] :
                  wr_pat ? pat_q[wr_pat_idx] : 32'h0;
  assign wr_val = merge_strb(wr_old, w_data_q, w_strb_q);
  assign pl_mask = wr_val[PRELOAD_MASK_LSB +: CELLS];
  assign pl_val = wr_val[PRELOAD_VAL_LSB +: CELLS];

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awvalid_in && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr_in;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid_in && !w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata_in;
        w_strb_q <= wstrb_in;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q <= MODE_RST;
      cellcfg_q <= CELLCFG_RST;
      secure_q <= 1'b0;
      sig_q[0] <= SIG_RST;
      sig_q[1] <= SIG_RST;
      for (int k = 0; k < PAT_WORDS; k++) begin
        pat_q[k] <= PAT_RST;
      end
    end else begin
      if (wr_mode && wr_val[1:0] != MODE_RESERVED) begin
        mode_q <= wr_val[1:0];
      end
      if (wr_cellcfg) begin
        cellcfg_q <= wr_val[15:0];
      end
      if (wr_secure && wr_val[SECURE_BIT]) begin
        secure_q <= 1'b1;
      end
      if (wr_sig_lo) begin
        sig_q[0] <= wr_val;
      end
      if (wr_sig_hi) begin
        sig_q[1] <= wr_val;
      end
      if (wr_pat) begin
        pat_q[wr_pat_idx] <= wr_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // macrocell registers and pin drivers
  // ----------------------------------------------------------------
  assign cell_d = !por_done ? '0 :
                  preload_go ? ((cell_q & ~pl_mask) | (pl_val & pl_mask)) :
                  clk_rise ? sum_term : cell_q;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cell_q <= '0;
      clk_pin_prev_q <= 1'b1;
      por_cnt_q <= '0;
      io_out_q <= '1;
      io_oe_q <= '0;
    end else begin
      cell_q <= cell_d;
      clk_pin_prev_q <= clk_pin_sync;
      por_cnt_q <= por_done ? por_cnt_q : por_cnt_q + POR_CNT_W'(1);
      io_out_q <= io_out_d;
      io_oe_q <= io_oe_d;
    end
  end

  assign io_pin_out = io_out_q;
  assign io_pin_oe_out = io_oe_q;
  assign powerup_done_out = por_done;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rd_take;
  logic rd_is_pat;
  logic rd_mapped;
  logic rd_err;
  logic [3:0] rd_pat_idx;
  logic [31:0] rd_status;
  logic [31:0] rd_val;

  assign arready_out = ~rvalid_q;
  assign rd_take = arvalid_in & ~rvalid_q;
  assign rd_is_pat = pat_addr(araddr_in);
  assign rd_pat_idx = 4'((araddr_in - PAT_BASE_OFS) >> 2);
  assign rd_status = {14'h0, mode_q, cell_q, 6'h0, por_done, secure_q};
  assign rd_mapped = rd_is_pat || (araddr_in == MODE_OFS) || (araddr_in == CELLCFG_OFS) ||
                     (araddr_in == SECURE_OFS) || (araddr_in == PRELOAD_OFS) || (araddr_in == STATUS_OFS) ||
                     (araddr_in == SIG_LO_OFS) || (araddr_in == SIG_HI_OFS);
  assign rd_err = ~rd_mapped | (rd_is_pat & secure_q);
  assign rd_val = rd_err ? 32'h0 :
                  rd_is_pat ? pat_q[rd_pat_idx] :
                  (araddr_in == MODE_OFS) ? {30'h0, mode_q} :
                  (araddr_in == CELLCFG_OFS) ? {16'h0, cellcfg_q} :
                  (araddr_in == SECURE_OFS) ? {31'h0, secure_q} :
                  (araddr_in == STATUS_OFS) ? rd_status :
                  (araddr_in == SIG_LO_OFS) ? sig_q[0] :
                  (araddr_in == SIG_HI_OFS) ? sig_q[1] : 32'h0;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;

endmodule : pld_core

// *** tb/board_model.sv ***
// board and programmer side: pin drivers around the logic block
module board_model
  import pld_cfg_pkg::*;
(
  // clock and status
  input wire logic clock_in,
  input wire logic done_in,
  // device pin drive
  input wire logic [CELLS-1:0] io_in,
  input wire logic [CELLS-1:0] io_oe_in,
  // pin levels
  output logic [CELLS-1:0] ded_out,
  output logic [CELLS-1:0] ded_drv_out,
  output logic clk_pin_out,
  output logic oe_b_out,
  output logic [CELLS-1:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CELLS-1:0] ded_q;

  // released lines show the inverse, so only the pull-up can make them read high
  assign ded_out = ded_q ^ ~ded_drv_out;
  assign io_out = io_in ^ ~io_oe_in;

  initial begin
    ded_q = 8'h00;
    ded_drv_out = 8'hff;
    clk_pin_out = 1'b0;
    oe_b_out = 1'b1;
  end

  task automatic set_pins(input logic [CELLS-1:0] v, input logic [CELLS-1:0] d, input logic oe_b);
    @(posedge clock_in);
    ded_q <= v;
    ded_drv_out <= d;
    oe_b_out <= oe_b;
  endtask : set_pins

  // one clock pin pulse, never inside the power-up interval
  task automatic pulse();
    while (done_in !== 1'b1) @(posedge clock_in);
    repeat (4) @(posedge clock_in);
    clk_pin_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    clk_pin_out <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask : pulse
endmodule : board_model

// *** tb/pld_core_properties.sv ***
// port-level assertions for the logic block
module pld_core_properties
  import pld_cfg_pkg::*;
#(
  parameter int NUM_CELLS = CELLS
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // read channel
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic rvalid_out,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0] rresp_out,
  // pins and status
  input wire logic [CELLS-1:0] io_pin_out,
  input wire logic [CELLS-1:0] io_pin_oe_out,
  input wire logic powerup_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cnt_q;
  logic [ADDR_W-1:0] ra_q;

  // edges since release, and the address of the read in flight
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      ra_q <= '0;
    end else begin
      if (cnt_q != 9'h1ff) cnt_q <= cnt_q + 9'h1;
      if (arvalid_in && arready_out) ra_q <= araddr_in;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  a_release_outs_high: assert property ($rose(rst_b_in) |-> io_pin_out == 8'hff && io_pin_oe_out == 8'h00)
    else $error("outputs not high at release");
  a_done_not_early: assert property (cnt_q < POR_CYCLES |-> !powerup_done_out)
    else $error("power-up done too early");
  a_done_not_late: assert property (cnt_q >= POR_CYCLES |-> powerup_done_out)
    else $error("power-up done too late");
  a_done_sticky: assert property (powerup_done_out |=> powerup_done_out)
    else $error("power-up done dropped");
  a_read_one_cycle: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read answer late");
  a_read_blocks_addr: assert property (rvalid_out |-> !arready_out)
    else $error("read address taken while answering");
  a_error_zero_data: assert property (rvalid_out && rresp_out == RESP_SLVERR |-> rdata_out == 32'h0)
    else $error("refused read returned data");
  a_regs_held_early: assert property (rvalid_out && ra_q == STATUS_OFS && !powerup_done_out
    |-> rdata_out[15:8] == 8'h00)
    else $error("registers not low during power-up");
  a_sig_always_okay: assert property (rvalid_out && (ra_q == SIG_LO_OFS || ra_q == SIG_HI_OFS)
    |-> rresp_out == RESP_OKAY)
    else $error("signature read refused");

  c_refused: cover property (rvalid_out && rresp_out == RESP_SLVERR);
  c_done: cover property ($rose(powerup_done_out));
  c_drive: cover property (io_pin_oe_out == 8'hff);
endmodule : pld_core_properties

bind pld_core pld_core_properties #(.NUM_CELLS(NUM_CELLS)) u_pld_core_properties (
  .clock_in, .rst_b_in, .arvalid_in, .arready_out, .araddr_in, .rvalid_out,
  .rdata_out, .rresp_out, .io_pin_out, .io_pin_oe_out, .powerup_done_out
);

// *** tb/tb_top.sv ***
// self-checking bench: bus master, board model and scenarios
module tb_top
  import pld_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, rst_b_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, done, clk_pin, oe_b;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [CELLS-1:0] ded, ded_drv, io_lvl, io_out, io_oe;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  pld_core u_pld_core (
    .clock_in(clock_in), .rst_b_in(rst_b_in),
    .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr),
    .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata), .wstrb_in(4'hf),
    .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
    .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
    .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata), .rresp_out(rresp),
    .ded_pin_in(ded), .ded_pin_driven_in(ded_drv), .pld_clk_pin_in(clk_pin), .pld_clk_driven_in(1'b1),
    .oe_b_pin_in(oe_b), .oe_b_driven_in(1'b1), .io_pin_in(io_lvl), .io_pin_driven_in(io_oe),
    .io_pin_out(io_out), .io_pin_oe_out(io_oe), .powerup_done_out(done)
  );
  board_model u_board_model (
    .clock_in(clock_in), .done_in(done), .io_in(io_out), .io_oe_in(io_oe), .ded_out(ded),
    .ded_drv_out(ded_drv), .clk_pin_out(clk_pin), .oe_b_out(oe_b), .io_out(io_lvl)
  );

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input string what, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    forever begin
      @(posedge clock_in);
      if (!pa && !pw && bvalid) break;
      if (awready) pa = 1'b0;
      if (wready) pw = 1'b0;
      awvalid <= pa;
      wvalid <= pw;
    end
    chk(what, {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t;
    t = 1'b0;
    {araddr, arvalid, rready} <= {a, 2'b11};
    forever begin
      @(posedge clock_in);
      if (t && rvalid) break;
      if (arready) t = 1'b1;
      arvalid <= !t;
    end
    chk(what, ed, rdata);
    chk(what, {30'h0, er}, {30'h0, rresp});
  endtask : rd

  function automatic logic [31:0] stat(input logic [7:0] regs, input logic sec);
    return {14'h0, MODE_REGISTERED, regs, 6'h0, 1'b1, sec};
  endfunction : stat

  task automatic t_reset();
    chk("outs", 32'hff, {24'h0, io_out});
    chk("oe", 32'h0, {24'h0, io_oe});
    rd("status early", STATUS_OFS, 32'h0, RESP_OKAY);
    rd("mode", MODE_OFS, {30'h0, MODE_RST}, RESP_OKAY);
    rd("cellcfg", CELLCFG_OFS, {16'h0, CELLCFG_RST}, RESP_OKAY);
    while (done !== 1'b1) @(posedge clock_in);
    rd("status done", STATUS_OFS, 32'h2, RESP_OKAY);
    $display("test reset ended");
  endtask : t_reset

  task automatic t_modes();
    for (logic [31:0] m = 0; m < 4; m++) begin
      wr("mode wr", MODE_OFS, m, RESP_OKAY);
      rd("mode rd", MODE_OFS, (m == 32'h3) ? 32'h2 : m, RESP_OKAY);
    end
    wr("cell codes", CELLCFG_OFS, 32'h0000_e4e4, RESP_OKAY);
    rd("cell codes", CELLCFG_OFS, 32'h0000_e4e4, RESP_OKAY);
    chk("oe registered", 32'h66, {24'h0, io_oe});
    wr("oe term", PAT_BASE_OFS + 8'(4 * CELLS), 32'h1, RESP_OKAY);
    wr("complex", MODE_OFS, {30'h0, MODE_COMPLEX}, RESP_OKAY);
    rd("complex", MODE_OFS, {30'h0, MODE_COMPLEX}, RESP_OKAY);
    chk("oe complex", 32'h76, {24'h0, io_oe});
    wr("simple", MODE_OFS, {30'h0, MODE_SIMPLE}, RESP_OKAY);
    rd("simple", MODE_OFS, {30'h0, MODE_SIMPLE}, RESP_OKAY);
    chk("oe simple", 32'h77, {24'h0, io_oe});
    wr("registered", MODE_OFS, {30'h0, MODE_REGISTERED}, RESP_OKAY);
    $display("test modes ended");
  endtask : t_modes

  task automatic t_capture();
    wr("cells reg", CELLCFG_OFS, 32'h0, RESP_OKAY);
    for (int i = 0; i < CELLS; i++) begin
      wr("term", PAT_BASE_OFS + 8'(4 * i), 32'h1 << i, RESP_OKAY);
    end
    u_board_model.set_pins(8'ha5, 8'hff, 1'b0);
    u_board_model.pulse();
    rd("loaded", STATUS_OFS, stat(8'ha5, 1'b0), RESP_OKAY);
    chk("reg outs", 32'h5a, {24'h0, io_out});
    chk("reg oe on", 32'hff, {24'h0, io_oe});
    u_board_model.set_pins(8'ha5, 8'h00, 1'b1);
    repeat (4) @(posedge clock_in);
    chk("reg oe off", 32'h0, {24'h0, io_oe});
    u_board_model.pulse();
    rd("pulled high", STATUS_OFS, stat(8'hff, 1'b0), RESP_OKAY);
    wr("preload", PRELOAD_OFS, 32'h0000_0a0f, RESP_OKAY);
    rd("preload low", STATUS_OFS, stat(8'hfa, 1'b0), RESP_OKAY);
    wr("preload", PRELOAD_OFS, 32'h0000_3cff, RESP_OKAY);
    rd("preload mix", STATUS_OFS, stat(8'h3c, 1'b0), RESP_OKAY);
    $display("test capture ended");
  endtask : t_capture

  task automatic t_secure();
    wr("sig lo", SIG_LO_OFS, 32'h1234_5678, RESP_OKAY);
    wr("sig hi", SIG_HI_OFS, 32'h9abc_def0, RESP_OKAY);
    rd("pat open", PAT_BASE_OFS, 32'h1, RESP_OKAY);
    wr("fuse", SECURE_OFS, 32'h1, RESP_OKAY);
    wr("fuse clr", SECURE_OFS, 32'h0, RESP_OKAY);
    rd("secured", STATUS_OFS, stat(8'h3c, 1'b1), RESP_OKAY);
    rd("pat shut", PAT_BASE_OFS + 8'h04, 32'h0, RESP_SLVERR);
    wr("preload shut", PRELOAD_OFS, 32'h0000_00ff, RESP_SLVERR);
    rd("regs kept", STATUS_OFS, stat(8'h3c, 1'b1), RESP_OKAY);
    rd("sig lo", SIG_LO_OFS, 32'h1234_5678, RESP_OKAY);
    wr("sig hi", SIG_HI_OFS, 32'h0fed_cba9, RESP_OKAY);
    rd("sig hi", SIG_HI_OFS, 32'h0fed_cba9, RESP_OKAY);
    rd("unmapped", 8'h20, 32'h0, RESP_SLVERR);
    wr("unmapped", 8'h24, 32'h5, RESP_SLVERR);
    $display("test secure ended");
  endtask : t_secure

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  initial begin
    rst_b_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
    {awaddr, araddr, wdata} = '0;
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_modes();
    t_capture();
    t_secure();
    close_out();
  end
endmodule : tb_top
